/* shared/link_selftest_map.svh */
// Constants of the link self-test controller: register offsets, fields,
// reset values and the remote serializer register that is programmed.
// Assumes an 8-bit register space reached one byte at a time.
`ifndef LINK_SELFTEST_MAP_SVH
`define LINK_SELFTEST_MAP_SVH

// Register offsets
`define OFS_ERROR_TALLY 8'h57
`define OFS_PORT_SELECT 8'h4C
`define OFS_CONTROL 8'hB3
`define OFS_PIN_CTL_BASE 8'h10

// Control register fields
`define CTL_ENABLE_BIT 0
`define CTL_CLKSEL_LSB 1
`define CTL_GATING_LSB 6
`define CTL_START_VALUE 8'h01
`define CTL_RESET 8'h00

// Output gating codes
`define GATING_DISABLED 2'h0
`define GATING_ENABLED 2'h2

// Port select register fields and reset
`define PSEL_READ_LSB 4
`define PSEL_RESET 8'h00

// Pin source control fields and reset
`define PIN_PORT_LSB 0
`define PIN_SRC_PASS_BIT 2
`define PIN_DRIVE_BIT 3
`define PIN_CTL_RESET 8'h00

// Error tally values
`define TALLY_FAIL 8'hFF
`define TALLY_MAX 8'hFE

// Remote serializer test register and its bits
`define REMOTE_TEST_REG 8'h14
`define REMOTE_CLKSEL_LSB 1
`define REMOTE_TEST_ON 8'h01
`define REMOTE_TEST_OFF 8'h00

// Unmapped register read value
`define READ_UNMAPPED 8'h00

`endif

/* shared/link_selftest_pkg.sv */
// Types shared by the link self-test controller files.
// Assumes the constants header is compiled alongside.
`default_nettype none

package link_selftest_pkg;

    // Test sequencing states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START_WR = 2'b01,
        ST_RUN = 2'b10,
        ST_STOP_WR = 2'b11
    } test_state_e;

    // One back-channel register write: address then data
    typedef logic [15:0] bc_write_t;

endpackage

`default_nettype wire

/* src/bc_write_buffer.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock; the draining side may stall at any time.
`default_nettype none

module bc_write_buffer #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    logic [WIDTH-1:0] mem_r [2];
    logic wr_idx_r;
    logic rd_idx_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    // Handshakes
    assign in_ready_o = (count_r != 2'h2);
    assign out_valid_o = (count_r != 2'h0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_r[rd_idx_r];

    // Storage
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else if (push) begin
            mem_r[wr_idx_r] <= in_data_i;
        end
    end

    // Pointers and fill level
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_idx_r <= 1'b0;
            rd_idx_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) wr_idx_r <= ~wr_idx_r;
            if (pop) rd_idx_r <= ~rd_idx_r;
            if (push && !pop) count_r <= count_r + 2'h1;
            else if (pop && !push) count_r <= count_r - 2'h1;
        end
    end

endmodule

`default_nettype wire

/* src/link_selftest_ctrl.sv */
// Link self-test controller: control register, remote setup over the
// back channel, per-port pseudo-random checking, tallies and pin routing.
// Assumes receive words arrive on clk_i; lock flags come from another domain.
`include "link_selftest_map.svh"
`default_nettype none

module link_selftest_ctrl
    import link_selftest_pkg::*;
#(
    parameter int PORTS = 4,
    parameter int DATA_W = 8,
    parameter int PINS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register access port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Back-channel register writes to the remote serializer
    output logic bc_valid_o,
    input wire logic bc_ready_i,
    output logic [7:0] bc_addr_o,
    output logic [7:0] bc_data_o,
    // Receive ports
    input wire logic [PORTS-1:0] rx_lock_i,
    input wire logic [PORTS-1:0] rx_valid_i,
    input wire logic [PORTS*DATA_W-1:0] rx_data_i,
    // Pass indications and general-purpose pins
    output logic [PORTS-1:0] pass_o,
    output logic [PINS-1:0] gpio_o,
    output logic [PINS-1:0] gpio_oe_o,
    // Output gating and neighbouring functions
    output logic test_active_o,
    output logic outputs_enable_o,
    input wire logic patgen_req_i,
    output logic patgen_enable_o,
    output logic csi_lp11_o,
    input wire logic monitor_req_i,
    output logic monitor_enable_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    test_state_e state_r;
    logic [7:0] control_r;
    logic [7:0] port_select_r;
    logic [7:0] pin_ctl_r [PINS];
    logic [1:0] clk_sel_r;
    logic [PORTS-1:0] lock_meta_r;
    logic [PORTS-1:0] lock_sync_r;
    logic [PORTS-1:0] ever_locked_r;
    logic [PORTS-1:0] lost_lock_r;
    logic [PORTS-1:0] primed_r;
    logic [6:0] history_r [PORTS];
    logic [7:0] count_r [PORTS];
    logic [PORTS-1:0] word_err;
    logic [6:0] history_nxt [PORTS];
    logic [7:0] tally [PORTS];
    logic running;
    logic checking;
    logic start_req;
    logic stop_req;
    logic ctl_write;
    logic buf_in_valid;
    logic buf_in_ready;
    bc_write_t buf_in_data;
    bc_write_t buf_out_data;
    logic [1:0] read_port;
    logic [7:0] read_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Control register and test start/stop

    assign ctl_write = reg_wr_i && (reg_addr_i == `OFS_CONTROL);
    assign start_req = ctl_write && reg_wdata_i[`CTL_ENABLE_BIT];
    assign stop_req = ctl_write && !reg_wdata_i[`CTL_ENABLE_BIT];
    assign running = (state_r == ST_START_WR) || (state_r == ST_RUN);
    assign checking = (state_r == ST_RUN);

    // Software-visible control byte
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            control_r <= `CTL_RESET;
        end else if (ctl_write) begin
            control_r <= reg_wdata_i;
        end
    end

    // Port select and pin source registers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_select_r <= `PSEL_RESET;
            for (int p = 0; p < PINS; p++) pin_ctl_r[p] <= `PIN_CTL_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `OFS_PORT_SELECT) port_select_r <= reg_wdata_i;
            for (int p = 0; p < PINS; p++) begin
                if (reg_addr_i == `OFS_PIN_CTL_BASE + 8'(p)) pin_ctl_r[p] <= reg_wdata_i;
            end
        end
    end

    // Clock select captured once as the test starts
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            clk_sel_r <= 2'h0;
        end else if (state_r == ST_IDLE && start_req) begin
            clk_sel_r <= reg_wdata_i[`CTL_CLKSEL_LSB +: 2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test sequencer

    // Queues the remote setup write on start and the remote stop write on stop
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_req) state_r <= ST_START_WR;
                end
                ST_START_WR: begin
                    if (buf_in_ready) state_r <= ST_RUN;
                end
                ST_RUN: begin
                    if (stop_req) state_r <= ST_STOP_WR;
                end
                ST_STOP_WR: begin
                    if (buf_in_ready) state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Back-channel write path

    // Remote test register carries the enable and the captured clock select
    always_comb begin
        buf_in_valid = 1'b0;
        buf_in_data = {`REMOTE_TEST_REG, `REMOTE_TEST_OFF};
        if (state_r == ST_START_WR) begin
            buf_in_valid = 1'b1;
            buf_in_data = {`REMOTE_TEST_REG,
                           `REMOTE_TEST_ON | 8'({clk_sel_r, 1'b0})};
        end else if (state_r == ST_STOP_WR) begin
            buf_in_valid = 1'b1;
        end
    end

    bc_write_buffer #(
        .WIDTH(16)
    ) u_bc_buffer (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(buf_in_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i(buf_in_data),
        .out_valid_o(bc_valid_o),
        .out_ready_i(bc_ready_i),
        .out_data_o(buf_out_data)
    );

    assign bc_addr_o = buf_out_data[15:8];
    assign bc_data_o = buf_out_data[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Lock synchronisers

    // Two stages before any logic reads the lock flags
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lock_meta_r <= '0;
            lock_sync_r <= '0;
        end else begin
            lock_meta_r <= rx_lock_i;
            lock_sync_r <= lock_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pseudo-random checkers, one per port

    // Self-synchronising x^7+x^6+1 check; bit 0 of a word is the first bit
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            logic [6:0] h;
            logic pred;
            logic bit_in;
            pred = 1'b0;
            bit_in = 1'b0;
            h = history_r[p];
            word_err[p] = 1'b0;
            for (int i = 0; i < DATA_W; i++) begin
                bit_in = rx_data_i[p*DATA_W + i];
                pred = h[6] ^ h[5];
                if (pred != bit_in) word_err[p] = 1'b1;
                h = {h[5:0], bit_in};
            end
            history_nxt[p] = h;
            if (!primed_r[p] || !checking || !rx_valid_i[p] || !lock_sync_r[p]) begin
                word_err[p] = 1'b0;
            end
        end
    end

    // Checker history; first locked word only seeds it
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            primed_r <= '0;
            for (int p = 0; p < PORTS; p++) history_r[p] <= 7'h00;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                if (!checking || !lock_sync_r[p]) begin
                    primed_r[p] <= 1'b0;
                end else if (rx_valid_i[p]) begin
                    history_r[p] <= history_nxt[p];
                    primed_r[p] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Error tallies and lock history

    // Cleared at start, saturating at the normal maximum
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int p = 0; p < PORTS; p++) count_r[p] <= 8'h00;
        end else begin
            for (int p = 0; p < PORTS; p++) begin
                if (state_r == ST_IDLE && start_req) begin
                    count_r[p] <= 8'h00;
                end else if (word_err[p] && count_r[p] != `TALLY_MAX) begin
                    count_r[p] <= count_r[p] + 8'h01;
                end
            end
        end
    end

    // Records whether each port ever locked and whether it lost lock
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ever_locked_r <= '0;
            lost_lock_r <= '0;
        end else if (state_r == ST_IDLE && start_req) begin
            ever_locked_r <= '0;
            lost_lock_r <= '0;
        end else if (checking) begin
            ever_locked_r <= ever_locked_r | lock_sync_r;
            lost_lock_r <= lost_lock_r | (ever_locked_r & ~lock_sync_r);
        end
    end

    // Tally seen by software
    always_comb begin
        for (int p = 0; p < PORTS; p++) begin
            if (!ever_locked_r[p] || lost_lock_r[p]) tally[p] = `TALLY_FAIL;
            else tally[p] = count_r[p];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pass indications

    // Low for one cycle on each detected error, high otherwise
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pass_o <= '1;
        end else begin
            pass_o <= ~word_err;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // General-purpose pin routing

    // Each pin shows a chosen port's pass or lock flag when driven
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gpio_o <= '0;
            gpio_oe_o <= '0;
        end else begin
            for (int p = 0; p < PINS; p++) begin
                logic [1:0] sel;
                sel = pin_ctl_r[p][`PIN_PORT_LSB +: 2];
                gpio_oe_o[p] <= pin_ctl_r[p][`PIN_DRIVE_BIT];
                if (pin_ctl_r[p][`PIN_SRC_PASS_BIT]) gpio_o[p] <= pass_o[sel];
                else gpio_o[p] <= lock_sync_r[sel];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output gating and neighbouring functions

    assign test_active_o = running;
    // Outputs stay on outside the test; during it the gating field decides
    assign outputs_enable_o = !running ||
        (control_r[`CTL_GATING_LSB +: 2] == `GATING_ENABLED);
    // Pattern generator usable whenever outputs are enabled
    assign patgen_enable_o = patgen_req_i && outputs_enable_o;
    // Transmitter held in LP11 during the test unless the generator runs
    assign csi_lp11_o = running && !patgen_enable_o;
    // Monitor output never blocked by the test
    assign monitor_enable_o = monitor_req_i;

    ////////////////////////////////////////////////////////////////////////
    // Register reads

    assign read_port = port_select_r[`PSEL_READ_LSB +: 2];

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        read_nxt = `READ_UNMAPPED;
        if (reg_addr_i == `OFS_CONTROL) begin
            read_nxt = control_r;
        end else if (reg_addr_i == `OFS_PORT_SELECT) begin
            read_nxt = port_select_r;
        end else if (reg_addr_i == `OFS_ERROR_TALLY) begin
            read_nxt = tally[read_port];
        end else begin
            for (int p = 0; p < PINS; p++) begin
                if (reg_addr_i == `OFS_PIN_CTL_BASE + 8'(p)) read_nxt = pin_ctl_r[p];
            end
        end
    end

    // Read data registered, valid one cycle after the strobe
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) reg_rdata_o <= read_nxt;
        end
    end

endmodule

`default_nettype wire

/* test/link_selftest_ctrl_assertions.sv */
// Checker for the link self-test controller, watching top-level ports only.
// Assumes one clock domain; bound to every instance of the controller below.
`include "link_selftest_map.svh"
`default_nettype none

module link_selftest_ctrl_checker #(
    parameter int PORTS = 4,
    parameter int DATA_W = 8,
    parameter int PINS = 4
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_rvalid_o,
    // Back channel
    input wire logic bc_valid_o,
    input wire logic bc_ready_i,
    input wire logic [7:0] bc_addr_o,
    input wire logic [7:0] bc_data_o,
    // Receive side and gating
    input wire logic [PORTS-1:0] rx_valid_i,
    input wire logic [PORTS-1:0] pass_o,
    input wire logic test_active_o,
    input wire logic outputs_enable_o,
    input wire logic patgen_req_i,
    input wire logic patgen_enable_o,
    input wire logic csi_lp11_o,
    input wire logic monitor_req_i,
    input wire logic monitor_enable_o
);
    logic [1:0] gating_r;

    ////////////////////////////////////////////////////////////////////////
    // Shadow of the stored gating field
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gating_r <= 2'h0;
        end else if (reg_wr_i && reg_addr_i == `OFS_CONTROL) begin
            gating_r <= reg_wdata_i[7:6];
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////////////
    // Properties
    property p_rd_answer;
        reg_rd_i |=> reg_rvalid_o;
    endproperty
    property p_rd_only;
        reg_rvalid_o |-> $past(reg_rd_i);
    endproperty
    property p_start;
        $rose(test_active_o) |-> $past(reg_wr_i && reg_addr_i == `OFS_CONTROL && reg_wdata_i[0]);
    endproperty
    property p_stop;
        $fell(test_active_o) |-> $past(reg_wr_i && reg_addr_i == `OFS_CONTROL && !reg_wdata_i[0]);
    endproperty
    property p_remote_on;
        $rose(test_active_o) |-> ##[1:40] (bc_valid_o && bc_addr_o == `REMOTE_TEST_REG && bc_data_o[0]);
    endproperty
    property p_bc_hold;
        bc_valid_o && !bc_ready_i |=> bc_valid_o && $stable(bc_addr_o) && $stable(bc_data_o);
    endproperty
    property p_pass_cause;
        (~pass_o & ~$past(rx_valid_i)) == '0;
    endproperty
    property p_gating;
        outputs_enable_o == (!test_active_o || gating_r == `GATING_ENABLED);
    endproperty
    property p_lp11;
        csi_lp11_o == (test_active_o && !patgen_enable_o);
    endproperty
    property p_patgen;
        patgen_enable_o == (patgen_req_i && outputs_enable_o);
    endproperty
    property p_monitor;
        monitor_enable_o == monitor_req_i;
    endproperty

    ////////////////////////////////////////////////////////////////////////
    // Assertions and covers
    a_rd_answer: assert property (p_rd_answer) else $error("read strobe without answer");
    a_rd_only: assert property (p_rd_only) else $error("read answer without strobe");
    a_start: assert property (p_start) else $error("test began without start write");
    a_stop: assert property (p_stop) else $error("test ended without stop write");
    a_remote_on: assert property (p_remote_on) else $error("remote setup write missing");
    a_bc_hold: assert property (p_bc_hold) else $error("back-channel write changed");
    a_pass_cause: assert property (p_pass_cause) else $error("pass low without a word");
    a_gating: assert property (p_gating) else $error("output gating wrong");
    a_lp11: assert property (p_lp11) else $error("transmitter idle state wrong");
    a_patgen: assert property (p_patgen) else $error("pattern generator blocked");
    a_monitor: assert property (p_monitor) else $error("monitor output blocked");
    c_start: cover property ($rose(test_active_o));
    c_pass_low: cover property (pass_o != '1);
    c_stall: cover property (bc_valid_o && !bc_ready_i);
endmodule

bind link_selftest_ctrl link_selftest_ctrl_checker #(
    .PORTS(PORTS), .DATA_W(DATA_W), .PINS(PINS)
) chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
    .bc_valid_o(bc_valid_o), .bc_ready_i(bc_ready_i), .bc_addr_o(bc_addr_o),
    .bc_data_o(bc_data_o), .rx_valid_i(rx_valid_i), .pass_o(pass_o),
    .test_active_o(test_active_o), .outputs_enable_o(outputs_enable_o),
    .patgen_req_i(patgen_req_i), .patgen_enable_o(patgen_enable_o), .csi_lp11_o(csi_lp11_o),
    .monitor_req_i(monitor_req_i), .monitor_enable_o(monitor_enable_o)
);

`default_nettype wire

/* test/remote_serializer_model.sv */
// Behavioural remote serializer: takes back-channel writes, sends test words.
// Assumes four ports of 8-bit words; the bench commands stalls and bit errors.
`default_nettype none

module remote_serializer_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Back-channel writes and commanded faults
    input wire logic bc_valid_i,
    input wire logic [7:0] bc_addr_i,
    input wire logic [7:0] bc_data_i,
    input wire logic stall_i,
    input wire logic err_i,
    // Forward link words
    output logic bc_ready_o,
    output logic [3:0] rx_valid_o,
    output logic [31:0] rx_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] test_reg_r;
    logic [6:0] hist_r;
    int n_writes;

    ////////////////////////////////////////////////////////////////////////
    // Back-channel register file, slow when stalled
    assign bc_ready_o = !stall_i;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            test_reg_r <= 8'h00;
            n_writes <= 0;
        end else if (bc_valid_i && bc_ready_o) begin
            if (bc_addr_i == 8'h14) test_reg_r <= bc_data_i;
            n_writes <= n_writes + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Continuous pseudo-random words while the test bit is set
    always_ff @(posedge clk_i or negedge resetn_i) begin
        logic [6:0] h;
        logic [7:0] w;
        if (!resetn_i) begin
            hist_r <= 7'h7F;
            rx_valid_o <= 4'h0;
            rx_data_o <= 32'h0;
        end else if (test_reg_r[0]) begin
            h = hist_r;
            for (int i = 0; i < 8; i++) begin
                w[i] = h[6] ^ h[5];
                h = {h[5:0], w[i]};
            end
            hist_r <= h;
            rx_valid_o <= 4'hF;
            rx_data_o <= {w, w, w, w ^ {7'h0, err_i}};
        end else begin
            rx_valid_o <= 4'h0;
            rx_data_o <= ~rx_data_o;
        end
    end
endmodule

`default_nettype wire

/* test/serial_link_selftest_control_tb_top.sv */
// Self-checking bench for the link self-test controller.
// Assumes the remote serializer model and the bound checker are compiled.
`default_nettype none

module serial_link_selftest_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, bc_valid_o, bc_ready_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, bc_addr_o, bc_data_o;
    logic [3:0] rx_lock_i, rx_valid_i, pass_o, gpio_o, gpio_oe_o;
    logic [31:0] rx_data_i;
    logic test_active_o, outputs_enable_o, patgen_req_i, patgen_enable_o, csi_lp11_o;
    logic monitor_req_i, monitor_enable_o, stall, err;
    int n_mismatch = 0, comparisons = 0, n_pass_low, n_gpio_low;

`define CHECK(act, exp) begin comparisons++; if ((act) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp); end end

    ////////////////////////////////////////////////////////////////////////
    // Design, partner and clock
    link_selftest_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .bc_valid_o(bc_valid_o),
        .bc_ready_i(bc_ready_i), .bc_addr_o(bc_addr_o), .bc_data_o(bc_data_o),
        .rx_lock_i(rx_lock_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .pass_o(pass_o),
        .gpio_o(gpio_o), .gpio_oe_o(gpio_oe_o), .test_active_o(test_active_o),
        .outputs_enable_o(outputs_enable_o), .patgen_req_i(patgen_req_i),
        .patgen_enable_o(patgen_enable_o), .csi_lp11_o(csi_lp11_o),
        .monitor_req_i(monitor_req_i), .monitor_enable_o(monitor_enable_o));
    remote_serializer_model ser_u (.clk_i(clk_i), .resetn_i(resetn_i), .bc_valid_i(bc_valid_o),
        .bc_addr_i(bc_addr_o), .bc_data_i(bc_data_o), .stall_i(stall), .err_i(err),
        .bc_ready_o(bc_ready_i), .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // Low-pulse counters for port 0 pass and pin 0
    always @(posedge clk_i) begin
        if (pass_o[0] === 1'b0) n_pass_low++;
        if (gpio_o[0] === 1'b0 && gpio_oe_o[0] === 1'b1) n_gpio_low++;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register access and waits
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, a, d};
        @(posedge clk_i) reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge clk_i) reg_rd_i <= 1'b0;
        @(negedge clk_i);
        `CHECK(reg_rvalid_o, 1'b1)
        `CHECK(reg_rdata_o, exp)
    endtask
    task automatic tally(input logic [1:0] p, input logic [7:0] exp);
        wr(8'h4C, {2'h0, p, 4'h0});
        rd(8'h57, exp);
    endtask
    task automatic wait_remote(input logic [7:0] exp);
        int i;
        for (i = 0; i < 50 && ser_u.test_reg_r !== exp; i++) @(posedge clk_i);
        if (i == 50) begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs;
        rd(8'hB3, 8'h00);
        wr(8'h4C, 8'h5A);
        rd(8'h4C, 8'h5A);
        wr(8'h80, 8'h12);
        rd(8'h80, 8'h00);
        wr(8'h10, 8'h0C);
        rd(8'h10, 8'h0C);
        wr(8'h11, 8'h0B);
    endtask
    task automatic t_first_run;
        rx_lock_i <= 4'hF;
        stall <= 1'b1;
        wr(8'hB3, 8'h85);
        repeat (6) @(posedge clk_i);
        `CHECK(bc_valid_o, 1'b1)
        `CHECK(ser_u.n_writes, 0)
        `CHECK(csi_lp11_o, 1'b1)
        stall <= 1'b0;
        wait_remote(8'h05);
        patgen_req_i <= 1'b1;
        monitor_req_i <= 1'b1;
        repeat (20) @(posedge clk_i);
        `CHECK(patgen_enable_o, 1'b1)
        `CHECK(monitor_enable_o, 1'b1)
        `CHECK(gpio_oe_o[0], 1'b1)
        `CHECK(gpio_o[1], 1'b1)
        {n_pass_low, n_gpio_low} = 0;
        @(posedge clk_i) err <= 1'b1;
        @(posedge clk_i) err <= 1'b0;
        wr(8'hB3, 8'h83);
        rx_lock_i[3] <= 1'b0;
        repeat (20) @(posedge clk_i);
        `CHECK(n_pass_low, 1)
        `CHECK(n_gpio_low, 1)
        `CHECK(gpio_o[1], 1'b0)
        `CHECK(ser_u.n_writes, 1)
        wr(8'hB3, 8'h00);
        wait_remote(8'h00);
        `CHECK(ser_u.n_writes, 2)
        for (int p = 0; p < 4; p++) begin
            tally(2'(p), p == 0 ? 8'h01 : (p == 3 ? 8'hFF : 8'h00));
        end
    endtask
    task automatic t_saturate;
        rx_lock_i <= 4'hF;
        repeat (3) @(posedge clk_i);
        wr(8'hB3, 8'h03);
        wait_remote(8'h03);
        `CHECK(outputs_enable_o, 1'b0)
        `CHECK(patgen_enable_o, 1'b0)
        tally(2'd3, 8'h00);
        tally(2'd0, 8'h00);
        @(posedge clk_i) err <= 1'b1;
        repeat (300) @(posedge clk_i);
        err <= 1'b0;
        tally(2'd0, 8'hFE);
        wr(8'hB3, 8'h00);
        wait_remote(8'h00);
        `CHECK(outputs_enable_o, 1'b1)
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Closing report and main sequence
    task automatic tally_and_finish;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        {resetn_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {rx_lock_i, patgen_req_i, monitor_req_i, stall, err} = '0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_regs();
        t_first_run();
        t_saturate();
        tally_and_finish();
    end
endmodule

`default_nettype wire
